// ===== scs_pkg.sv
package scs_pkg;
    localparam int          WORD_BITS      = 8;
    localparam int          FIFO_DEPTH     = 4;
    localparam int          PTR_BITS       = 2;
    localparam int          CNT_BITS       = 3;
    localparam logic [1:0]  MODE_SPI       = 2'h2;
    localparam int          REF_MHZ        = 24;
    localparam int          CLK_MHZ        = 100;
    localparam logic [3:0]  RATE_RESET     = 4'h0;
    localparam logic [7:0]  BUSY_TOKEN     = 8'hff;
    localparam logic [7:0]  TX_RESET       = 8'h00;
    localparam int          IRQ_BITS       = 8;
    localparam int          IRQ_TXIDLE     = 0;
    localparam int          IRQ_TXFREE     = 1;
    localparam int          IRQ_RXVAL      = 2;
    localparam int          IRQ_TXDMA_DONE = 3;
    localparam int          IRQ_RXDMA_DONE = 4;
    localparam int          IRQ_RXOVR      = 5;
    localparam int          IRQ_TXUND      = 6;
    localparam int          IRQ_RXDMA_ERR  = 7;
    // Reference ticks as a 16.16 phase accumulator increment on clock_i.
    localparam logic [31:0] REF_INC = 32'(longint'(REF_MHZ) * 65536 / CLK_MHZ);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} scs_state_t;
endpackage : scs_pkg

// ===== scs_fifo.sv
`timescale 1ns/100ps
module scs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_o != (PW+1)'(DEPTH));
    assign out_valid_o = (count_o != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count_o <= '0;
        end else if (flush_i) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count_o <= '0;
        end else begin
            if (push) begin
                wr_ptr <= PW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= PW'(rd_ptr + 1'b1);
            end
            count_o <= (PW+1)'(count_o + push - pop);
        end
    end
endmodule : scs_fifo

// ===== scs_spi_master.sv
`timescale 1ns/100ps
module scs_spi_master
    import scs_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    // Configuration
    input  wire logic [1:0]           controller_mode_select_i,
    input  wire logic                 master_enable_bit_i,
    input  wire logic                 clock_polarity_bit_i,
    input  wire logic                 clock_phase_bit_i,
    input  wire logic                 bit_order_bit_i,
    input  wire logic                 auto_repeat_enable_i,
    input  wire logic                 auto_repeat_select_i,
    input  wire logic [3:0]           rate_multiplier_reg_i,
    input  wire logic [3:0]           rate_power_shift_reg_i,
    // Transmit data from software or DMA
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    input  wire logic [WORD_BITS-1:0] tx_data_i,
    // Receive data to software or DMA
    output logic                      rx_valid_o,
    input  wire logic                 rx_ready_i,
    output logic      [WORD_BITS-1:0] rx_data_o,
    // DMA engine status
    input  wire logic                 tx_dma_buffer_active_i,
    input  wire logic                 rx_dma_buffer_active_i,
    input  wire logic                 rx_dma_active_i,
    input  wire logic                 dma_channel_reset_bits_i,
    input  wire logic                 rx_dma_buffer_load_i,
    // Status
    output logic                      tx_idle_flag_o,
    output logic                      tx_free_flag_o,
    output logic                      rx_valid_flag_o,
    output logic                      rx_overflow_flag_o,
    output logic                      rx_dma_error_o,
    // Interrupts
    input  wire logic [IRQ_BITS-1:0]  serial_irq_mask_reg_i,
    input  wire logic                 top_irq_enable_i,
    input  wire logic [IRQ_BITS-1:0]  irq_clear_i,
    output logic      [IRQ_BITS-1:0]  serial_irq_flag_reg_o,
    output logic                      irq_o,
    // SPI pins
    output logic                      spi_clock_o,
    output logic                      serial_out_pin_o,
    input  wire logic                 serial_in_pin_i
);

    ////////////////////////////////////////////////////////////////////////
    logic                 active;
    scs_state_t           state;
    logic [31:0]          ref_acc;
    logic                 ref_tick;
    logic [18:0]          div_cnt;
    logic [18:0]          div_top;
    logic                 half_tick;
    logic [2:0]           bit_cnt;
    logic [WORD_BITS-1:0] tx_shift;
    logic [WORD_BITS-1:0] rx_shift;
    logic [WORD_BITS-1:0] rx_word;
    logic [WORD_BITS-1:0] last_tx;
    logic                 sampled;
    logic                 tx_pop;
    logic                 start;
    logic                 auto_start;
    logic                 word_done;
    logic                 rx_push_ok;
    logic                 rx_in_ready;
    logic [CNT_BITS-1:0]  tx_count;
    logic [CNT_BITS-1:0]  rx_count;
    logic                 tx_out_valid;
    logic [WORD_BITS-1:0] tx_out_data;
    logic                 ovr_pending;
    logic [4:0]           prev;
    logic [4:0]           now;
    logic [IRQ_BITS-1:0]  events;

    function automatic logic [WORD_BITS-1:0] order(
        input logic [WORD_BITS-1:0] d,
        input logic                 lsb_first
    );
        logic [WORD_BITS-1:0] r;
        r = d;
        if (lsb_first) begin
            for (int i = 0; i < WORD_BITS; i++) begin
                r[i] = d[WORD_BITS-1-i];
            end
        end
        return r;
    endfunction : order

    assign active = (controller_mode_select_i == MODE_SPI)
                    && master_enable_bit_i;

    ////////////////////////////////////////////////////////////////////////
    // FIFOs. Data is stored in software order and reordered at the MSB-first shifter.

    scs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (!active),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .in_data_i   (tx_data_i),
        .out_valid_o (tx_out_valid),
        .out_ready_i (tx_pop),
        .out_data_o  (tx_out_data),
        .count_o     (tx_count)
    );

    assign rx_push_ok = word_done && rx_in_ready;
    // The last bit reaches rx_shift on the same edge as the push, so the
    // stored word takes that bit straight from where it is sampled.
    assign rx_word    = {rx_shift[WORD_BITS-2:0],
                         clock_phase_bit_i ? serial_in_pin_i : sampled};

    scs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (!active),
        .in_valid_i  (rx_push_ok),
        .in_ready_o  (rx_in_ready),
        .in_data_i   (order(rx_word, bit_order_bit_i)),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o),
        .count_o     (rx_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Rate generator. The 24MHz reference is a fractional tick on
    // clock_i, so edges jitter by one system cycle at most.

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_acc <= '0;
        end else begin
            ref_acc <= {16'h0000, ref_acc[15:0]} + REF_INC;
        end
    end

    assign ref_tick = ref_acc[16];
    assign div_top  = 19'(({15'h0000, rate_multiplier_reg_i} + 19'h1)
                      << rate_power_shift_reg_i) - 19'h1;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= '0;
        end else if (state == ST_IDLE) begin
            div_cnt <= '0;
        end else if (ref_tick) begin
            div_cnt <= (div_cnt >= div_top) ? '0 : 19'(div_cnt + 19'h1);
        end
    end

    assign half_tick = ref_tick && (div_cnt >= div_top);

    ////////////////////////////////////////////////////////////////////////
    // Serializer, eight bits per word, master only.

    assign auto_start = auto_repeat_enable_i && !tx_out_valid
                        && rx_in_ready;
    assign start      = active && (state == ST_IDLE)
                        && (tx_out_valid || auto_start);
    assign tx_pop     = start && tx_out_valid;
    assign word_done  = half_tick && (state == ST_TRAIL)
                        && (bit_cnt == 3'h7);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state    <= ST_IDLE;
            bit_cnt  <= '0;
            tx_shift <= TX_RESET;
            rx_shift <= '0;
            sampled  <= 1'b0;
        end else if (!active) begin
            state    <= ST_IDLE;
            bit_cnt  <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state   <= ST_LEAD;
                        bit_cnt <= '0;
                        if (tx_out_valid) begin
                            tx_shift <= order(tx_out_data, bit_order_bit_i);
                        end else if (auto_repeat_select_i) begin
                            tx_shift <= BUSY_TOKEN;
                        end else begin
                            tx_shift <= last_tx;
                        end
                    end
                end
                ST_LEAD: begin
                    if (half_tick) begin
                        state <= ST_TRAIL;
                        if (!clock_phase_bit_i) begin
                            sampled <= serial_in_pin_i;
                        end else if (bit_cnt != 3'h0) begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                        end
                    end
                end
                ST_TRAIL: begin
                    if (half_tick) begin
                        if (clock_phase_bit_i) begin
                            rx_shift <= {rx_shift[6:0],
                                         serial_in_pin_i};
                        end else begin
                            rx_shift <= {rx_shift[6:0], sampled};
                            tx_shift <= {tx_shift[6:0], 1'b0};
                        end
                        bit_cnt <= 3'(bit_cnt + 3'h1);
                        state   <= (bit_cnt == 3'h7) ? ST_IDLE : ST_LEAD;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_tx <= TX_RESET;
        end else if (tx_pop) begin
            last_tx <= order(tx_out_data, bit_order_bit_i);
        end
    end

    // In phase one the data line keeps its last bit while idle, so it does
    // not move on the final trailing edge, where the far side samples it.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_clock_o      <= 1'b0;
            serial_out_pin_o <= 1'b0;
        end else begin
            spi_clock_o      <= clock_polarity_bit_i
                                ^ (state == ST_TRAIL);
            serial_out_pin_o <= tx_shift[WORD_BITS-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags.

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_idle_flag_o     <= 1'b1;
            tx_free_flag_o     <= 1'b1;
            rx_valid_flag_o    <= 1'b0;
            rx_overflow_flag_o <= 1'b0;
        end else begin
            tx_idle_flag_o  <= (tx_count == '0)
                               && (state == ST_IDLE) && !start;
            tx_free_flag_o  <= tx_ready_o;
            rx_valid_flag_o <= (rx_count != '0);
            if (word_done && !rx_in_ready) begin
                rx_overflow_flag_o <= 1'b1;
            end else if (!active) begin
                rx_overflow_flag_o <= 1'b0;
            end
        end
    end

    // The DMA error waits for the receive FIFO to drain.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovr_pending    <= 1'b0;
            rx_dma_error_o <= 1'b0;
        end else begin
            if (word_done && !rx_in_ready && rx_dma_active_i) begin
                ovr_pending <= 1'b1;
            end else if (ovr_pending && rx_count == '0) begin
                ovr_pending <= 1'b0;
            end
            if (ovr_pending && rx_count == '0) begin
                rx_dma_error_o <= 1'b1;
            end else if (dma_channel_reset_bits_i
                         || rx_dma_buffer_load_i) begin
                rx_dma_error_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags: set wins over a clear in the same cycle.

    assign now = {rx_dma_buffer_active_i, tx_dma_buffer_active_i,
                  rx_valid_flag_o, tx_free_flag_o, tx_idle_flag_o};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 5'h03;
        end else begin
            prev <= now;
        end
    end

    always_comb begin
        events                 = '0;
        events[IRQ_TXIDLE]     = now[0] && !prev[0];
        events[IRQ_TXFREE]     = now[1] && !prev[1];
        events[IRQ_RXVAL]      = now[2] && !prev[2];
        events[IRQ_TXDMA_DONE] = !now[3] && prev[3];
        events[IRQ_RXDMA_DONE] = !now[4] && prev[4];
        events[IRQ_RXOVR]      = word_done && !rx_in_ready;
        events[IRQ_TXUND]      = start && auto_start;
        events[IRQ_RXDMA_ERR]  = ovr_pending && rx_count == '0;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_irq_flag_reg_o <= '0;
        end else begin
            serial_irq_flag_reg_o <= (serial_irq_flag_reg_o & ~irq_clear_i)
                                     | events;
        end
    end

    assign irq_o = top_irq_enable_i
                   && |(serial_irq_flag_reg_o & serial_irq_mask_reg_i);

endmodule : scs_spi_master

// ===== scs_spi_slave_model.sv
`timescale 1ns/100ps
module scs_spi_slave_model (
    // Configuration and clear
    input  wire logic       clear_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] reply_i,
    // Serial lines
    input  wire logic       spi_clock_i,
    input  wire logic       serial_out_pin_i,
    output logic            serial_in_pin_o,
    // Observed traffic
    output logic [7:0]      rx_byte_o,
    output int              bytes_o
);
    logic [2:0] smp = 3'h0;
    logic [2:0] sh  = 3'h0;
    logic [7:0] sr  = 8'h00;
    logic [2:0] idx;

    initial rx_byte_o = 8'h00;
    initial bytes_o = 0;

    // Edges seen while clear is high are polarity changes, not bits.
    always @(spi_clock_i or posedge clear_i) begin
        if (clear_i) begin
            smp = 3'h0;
            sh = 3'h0;
        end else if ((spi_clock_i != cpol_i) ^ cpha_i) begin
            if (lsb_i) begin
                sr = {serial_out_pin_i, sr[7:1]};
            end else begin
                sr = {sr[6:0], serial_out_pin_i};
            end
            smp = smp + 3'h1;
            if (smp == 3'h0) begin
                rx_byte_o = sr;
                bytes_o++;
            end
        end else begin
            sh = sh + 3'h1;
        end
    end

    // The reply bit moves only on the shift edge, so the master samples a
    // settled line.
    assign idx = cpha_i ? sh - 3'h1 : sh;
    assign serial_in_pin_o = reply_i[lsb_i ? idx : 3'h7 - idx];
endmodule : scs_spi_slave_model

// ===== scs_spi_master_monitor.sv
`timescale 1ns/100ps
module scs_spi_master_monitor import scs_pkg::*; (
    // Clock and reset
    input wire logic                clock_i,
    input wire logic                rst_n_i,
    // Watched ports
    input wire logic [1:0]          controller_mode_select_i,
    input wire logic                master_enable_bit_i,
    input wire logic                clock_polarity_bit_i,
    input wire logic                tx_valid_i,
    input wire logic                tx_ready_o,
    input wire logic                tx_idle_flag_o,
    input wire logic                tx_free_flag_o,
    input wire logic                rx_valid_o,
    input wire logic                rx_valid_flag_o,
    input wire logic                rx_overflow_flag_o,
    input wire logic [IRQ_BITS-1:0] serial_irq_mask_reg_i,
    input wire logic                top_irq_enable_i,
    input wire logic [IRQ_BITS-1:0] serial_irq_flag_reg_o,
    input wire logic                irq_o,
    input wire logic                spi_clock_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic act;
    assign act = controller_mode_select_i == MODE_SPI && master_enable_bit_i;

    irq_gate_a:
    assert property (irq_o == (top_irq_enable_i
        && |(serial_irq_flag_reg_o & serial_irq_mask_reg_i)))
    else $error("irq output disagrees with masks");
    clk_idle_a:
    assert property ((!act && $stable(clock_polarity_bit_i)) [*3]
        |-> spi_clock_o == clock_polarity_bit_i)
    else $error("serial clock not at idle level");
    free_track_a:
    assert property (1'b1 |=> tx_free_flag_o == $past(tx_ready_o))
    else $error("tx free flag wrong");
    rxv_track_a:
    assert property (1'b1 |=> rx_valid_flag_o == $past(rx_valid_o))
    else $error("rx valid flag wrong");
    idle_clear_a:
    assert property (act && tx_valid_i && tx_ready_o
        |-> ##[1:3] !tx_idle_flag_o)
    else $error("tx idle did not clear");
    idle_irq_a:
    assert property ($rose(tx_idle_flag_o)
        |-> ##[0:1] serial_irq_flag_reg_o[IRQ_TXIDLE])
    else $error("tx idle event lost");
    rxv_irq_a:
    assert property ($rose(rx_valid_flag_o)
        |-> ##[0:1] serial_irq_flag_reg_o[IRQ_RXVAL])
    else $error("rx valid event lost");
    ovf_irq_a:
    assert property ($rose(rx_overflow_flag_o)
        |-> ##[0:1] serial_irq_flag_reg_o[IRQ_RXOVR])
    else $error("overrun event lost");

    push_c: cover property (tx_valid_i && tx_ready_o);
    ovf_c: cover property ($rose(rx_overflow_flag_o));
    irq_c: cover property (irq_o);
endmodule : scs_spi_master_monitor

bind scs_spi_master scs_spi_master_monitor i_scs_spi_master_monitor (
    .clock_i, .rst_n_i, .controller_mode_select_i, .master_enable_bit_i,
    .clock_polarity_bit_i, .tx_valid_i, .tx_ready_o, .tx_idle_flag_o,
    .tx_free_flag_o, .rx_valid_o, .rx_valid_flag_o, .rx_overflow_flag_o,
    .serial_irq_mask_reg_i, .top_irq_enable_i, .serial_irq_flag_reg_o,
    .irq_o, .spi_clock_o
);

// ===== tb.sv
`timescale 1ns/100ps
module tb import scs_pkg::*;;
    logic [1:0] controller_mode_select_i = MODE_SPI;
    logic [3:0] rate_multiplier_reg_i = 4'h0, rate_power_shift_reg_i = 4'h0;
    logic [7:0] tx_data_i = 8'h00, irq_clear_i = 8'h00, mdl_reply = 8'h00;
    logic [7:0] serial_irq_mask_reg_i = 8'hff;
    logic clock_i = 0, rst_n_i = 0, master_enable_bit_i = 1, mdl_clr = 1,
        clock_polarity_bit_i = 0, clock_phase_bit_i = 0, bit_order_bit_i = 0,
        auto_repeat_enable_i = 0, auto_repeat_select_i = 0, tx_valid_i = 0,
        rx_ready_i = 0, tx_dma_buffer_active_i = 0, rx_dma_buffer_active_i = 0,
        rx_dma_active_i = 0, dma_channel_reset_bits_i = 0,
        rx_dma_buffer_load_i = 0, top_irq_enable_i = 0;
    logic tx_ready_o, rx_valid_o, tx_idle_flag_o, tx_free_flag_o, irq_o,
        rx_valid_flag_o, rx_overflow_flag_o, rx_dma_error_o, spi_clock_o,
        serial_out_pin_o, serial_in_pin_i;
    logic [7:0] rx_data_o, serial_irq_flag_reg_o, mdl_byte;
    int mdl_bytes, miscompares = 0, comparisons = 0;

    always #5 clock_i = ~clock_i;

    scs_spi_master i_scs_spi_master (
        .clock_i, .rst_n_i, .controller_mode_select_i, .master_enable_bit_i,
        .clock_polarity_bit_i, .clock_phase_bit_i, .bit_order_bit_i,
        .auto_repeat_enable_i, .auto_repeat_select_i, .rate_multiplier_reg_i,
        .rate_power_shift_reg_i, .tx_valid_i, .tx_ready_o, .tx_data_i,
        .rx_valid_o, .rx_ready_i, .rx_data_o, .tx_dma_buffer_active_i,
        .rx_dma_buffer_active_i, .rx_dma_active_i, .dma_channel_reset_bits_i,
        .rx_dma_buffer_load_i, .tx_idle_flag_o, .tx_free_flag_o,
        .rx_valid_flag_o, .rx_overflow_flag_o, .rx_dma_error_o,
        .serial_irq_mask_reg_i, .top_irq_enable_i, .irq_clear_i,
        .serial_irq_flag_reg_o, .irq_o, .spi_clock_o, .serial_out_pin_o,
        .serial_in_pin_i
    );
    scs_spi_slave_model i_scs_spi_slave_model (
        .clear_i(mdl_clr), .cpol_i(clock_polarity_bit_i),
        .cpha_i(clock_phase_bit_i), .lsb_i(bit_order_bit_i),
        .reply_i(mdl_reply), .spi_clock_i(spi_clock_o),
        .serial_out_pin_i(serial_out_pin_o), .serial_in_pin_o(serial_in_pin_i),
        .rx_byte_o(mdl_byte), .bytes_o(mdl_bytes)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick

    // Mode drops to zero around each change, and the model is held clear
    // while a polarity change moves the clock.
    task automatic cfg(input logic [2:0] k, input logic [3:0] m, e);
        mdl_clr <= 1'b1;
        controller_mode_select_i <= 2'h0;
        clock_polarity_bit_i <= k[0];
        clock_phase_bit_i <= k[1];
        bit_order_bit_i <= k[2];
        rate_multiplier_reg_i <= m;
        rate_power_shift_reg_i <= e;
        tick(4);
        controller_mode_select_i <= MODE_SPI;
        mdl_clr <= 1'b0;
        tick(1);
    endtask : cfg

    task automatic push(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            tx_data_i <= d + 8'(i);
            tx_valid_i <= 1'b1;
            @(negedge clock_i);
            while (tx_ready_o !== 1'b1) @(negedge clock_i);
            @(posedge clock_i);
        end
        tx_valid_i <= 1'b0;
    endtask : push

    task automatic pop(input logic [7:0] exp, input int n);
        for (int i = 0; i < n; i++) begin
            rx_ready_i <= 1'b1;
            @(negedge clock_i);
            chk(rx_valid_o, 1'b1);
            chk(rx_data_o, exp);
            @(posedge clock_i);
        end
        rx_ready_i <= 1'b0;
    endtask : pop

    task automatic drain_tx();
        tick(3);
        for (int i = 0; i < 30000 && tx_idle_flag_o !== 1'b1; i++) tick(1);
        tick(4);
    endtask : drain_tx

    task automatic wait_bytes(input int n);
        for (int i = 0; i < 3000 && mdl_bytes < n; i++) tick(1);
        tick(1);
    endtask : wait_bytes

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({tx_idle_flag_o, tx_free_flag_o, rx_valid_flag_o,
             rx_overflow_flag_o}, 8'h0c);
        chk({spi_clock_o, irq_o}, 8'h00);
        $display("Reset test done");
    endtask : t_reset

    task automatic t_modes();
        for (int k = 0; k < 8; k++) begin
            cfg(3'(k), 4'h0, 4'h0);
            mdl_reply <= 8'h3c + 8'(k);
            push(8'hc1 + 8'(k * 9), 1);
            drain_tx();
            chk(mdl_byte, 8'hc1 + 8'(k * 9));
            chk(spi_clock_o, 8'(k & 1));
            pop(8'h3c + 8'(k), 1);
        end
        $display("Frame format test done");
    endtask : t_modes

    // Bit periods are 50 and 133 cycles; the reference adds a cycle of jitter.
    task automatic t_rate();
        int p;
        realtime t0;
        for (int j = 0; j < 2; j++) begin
            cfg(3'h0, j ? 4'hf : 4'h2, j ? 4'h0 : 4'h1);
            push(8'h00, 1);
            @(posedge spi_clock_o);
            t0 = $realtime;
            @(posedge spi_clock_o);
            p = int'(($realtime - t0) / 10.0) - (j ? 133 : 50);
            chk(8'(p >= -2 && p <= 2), 8'h01);
            drain_tx();
            pop(8'h43, 1);
        end
        $display("Rate test done");
    endtask : t_rate

    task automatic t_fill();
        cfg(3'h0, 4'h0, 4'h0);
        mdl_reply <= 8'h5a;
        rx_dma_active_i <= 1'b1;
        irq_clear_i <= 8'hff;
        tick(1);
        irq_clear_i <= 8'h00;
        push(8'h20, 5);
        tick(2);
        chk({tx_ready_o, tx_free_flag_o}, 8'h00);
        drain_tx();
        chk({rx_overflow_flag_o, rx_dma_error_o}, 8'h02);
        chk(serial_irq_flag_reg_o & 8'h27, 8'h27);
        chk(irq_o, 1'b0);
        top_irq_enable_i <= 1'b1;
        tick(2);
        chk(irq_o, 1'b1);
        serial_irq_mask_reg_i <= 8'h00;
        tick(2);
        chk(irq_o, 1'b0);
        serial_irq_mask_reg_i <= 8'hff;
        pop(8'h5a, 4);
        tick(3);
        chk({rx_valid_flag_o, rx_dma_error_o}, 8'h01);
        dma_channel_reset_bits_i <= 1'b1;
        tx_dma_buffer_active_i <= 1'b1;
        rx_dma_buffer_active_i <= 1'b1;
        tick(1);
        dma_channel_reset_bits_i <= 1'b0;
        tx_dma_buffer_active_i <= 1'b0;
        rx_dma_buffer_active_i <= 1'b0;
        rx_dma_active_i <= 1'b0;
        tick(3);
        chk(rx_dma_error_o, 1'b0);
        chk(serial_irq_flag_reg_o & 8'h18, 8'h18);
        irq_clear_i <= 8'hff;
        tick(1);
        irq_clear_i <= 8'h00;
        tick(2);
        chk(serial_irq_flag_reg_o, 8'h00);
        chk(irq_o, 1'b0);
        $display("Fill and interrupt test done");
    endtask : t_fill

    task automatic t_repeat();
        int b;
        auto_repeat_select_i <= 1'b1;
        auto_repeat_enable_i <= 1'b1;
        wait_bytes(mdl_bytes + 2);
        chk(mdl_byte, BUSY_TOKEN);
        chk(serial_irq_flag_reg_o[IRQ_TXUND], 1'b1);
        auto_repeat_enable_i <= 1'b0;
        tick(200);
        b = mdl_bytes;
        tick(300);
        chk(8'(mdl_bytes - b), 8'h00);
        pop(8'h5a, 2);
        auto_repeat_select_i <= 1'b0;
        push(8'h96, 1);
        drain_tx();
        auto_repeat_enable_i <= 1'b1;
        wait_bytes(mdl_bytes + 2);
        chk(mdl_byte, 8'h96);
        auto_repeat_enable_i <= 1'b0;
        tick(200);
        $display("Repeat test done");
    endtask : t_repeat

    task automatic t_off();
        int b;
        for (int j = 0; j < 2; j++) begin
            controller_mode_select_i <= j ? MODE_SPI : 2'h1;
            master_enable_bit_i <= (j == 0);
            tick(2);
            b = mdl_bytes;
            tx_valid_i <= 1'b1;
            tick(1);
            tx_valid_i <= 1'b0;
            tick(300);
            chk(8'(mdl_bytes - b), 8'h00);
            chk(spi_clock_o, 1'b0);
        end
        $display("Inactive mode test done");
    endtask : t_off

    initial begin
        tick(16);
        rst_n_i <= 1'b1;
        tick(2);
        t_reset();
        t_modes();
        t_rate();
        t_fill();
        t_repeat();
        t_off();
        end_sim();
    end

    initial begin
        #400us;
        miscompares++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        end_sim();
    end
endmodule : tb
